// [hdl/tps_pkg.sv]
// Purpose: Shared constants and carrier types of the tile polygon setup block
// Assumes: Screen coordinates are unsigned integers, depth is unsigned fixed point
// Notes: Colours are packed as three 8-bit channels
package tps_pkg;
   // ***********************************************
   // Geometry and timing
   // ***********************************************
   localparam int COORD_W = 12;
   localparam int Z_W = 16;
   localparam int TILE_SHIFT = 5;
   localparam int TILE_W = COORD_W - TILE_SHIFT;
   localparam int POLY_ID_W = 16;
   localparam int DL_ADDR_W = 24;
   localparam int COL_W = 24;
   localparam int CH_W = 8;
   localparam int CNT_W = 7;
   localparam logic [CNT_W-1:0] DEPTH_SETUP_CYC = 7'h0e;
   localparam logic [CNT_W-1:0] SHADE_SETUP_MIN = 7'h30;
   localparam logic [CNT_W-1:0] SHADE_SETUP_MAX = 7'h46;
   localparam int CACHE_AW = 3;
   localparam int CACHE_DEPTH = 1 << CACHE_AW;
   localparam logic [31:0] CULL_MIN_DEFAULT = 32'h0000_0001;

   // ***********************************************
   // Enumerations
   // ***********************************************
   typedef enum logic [1:0] {
      SHAPE_TRI = 2'b00,
      SHAPE_QUAD = 2'b01,
      SHAPE_STRIP = 2'b10
   } tps_shape_t;

   typedef enum logic [2:0] {
      PT_FLAT = 3'b000,
      PT_GOURAUD = 3'b001,
      PT_TEX_FLAT = 3'b010,
      PT_TEX_GOURAUD = 3'b011,
      PT_TEX_FLAT_OFS = 3'b100,
      PT_TEX_GOURAUD_OFS = 3'b101
   } tps_ptype_t;

   // ***********************************************
   // Carriers
   // ***********************************************
   typedef struct packed {
      logic [COORD_W-1:0] x;
      logic [COORD_W-1:0] y;
      logic [Z_W-1:0] z;
   } tps_vertex_t;

   typedef struct packed {
      logic signed [31:0] a_num;
      logic signed [31:0] b_num;
      logic signed [47:0] c_num;
      logic signed [31:0] det;
      logic signed [63:0] quad_z_num;
      logic culled;
   } tps_plane_t;

   typedef struct packed {
      logic [TILE_W-1:0] tile_x;
      logic [TILE_W-1:0] tile_y;
      logic [POLY_ID_W-1:0] poly_id;
   } tps_dl_entry_t;

   typedef struct packed {
      logic [POLY_ID_W-1:0] poly_id;
      tps_ptype_t ptype;
      logic combine_add;
      logic visible;
      logic last;
      logic [TILE_SHIFT-1:0] px;
      logic [TILE_SHIFT-1:0] py;
      logic [COL_W-1:0] base_col;
      logic [COL_W-1:0] offset_col;
   } tps_frag_t;

   typedef struct packed {
      logic [COORD_W-1:0] x;
      logic [COORD_W-1:0] y;
      logic [COL_W-1:0] colour;
   } tps_pixel_t;
endpackage

// [hdl/tps_setup_core.sv]
// Purpose: Polygon intake, depth plane setup, tile binning and tile-ordered shading
// Assumes: Fragments arrive from the depth sort stage on the same clock
// Notes: Plane results are numerators over the determinant; divide downstream
//
// Summary of operation
// - Accept single triangles, single quads and strips of any length.
// - Quad fourth vertex depth comes from the plane of the first three.
// - Six primitive types: untextured, textured, textured with offset, each flat/Gouraud.
// - Shading colour combines base and offset colour as the control field selects.
// - Screen up to 4096 square is split into 32 by 32 tiles.
// - Each polygon that is not culled is listed for every tile it overlaps.
// - Binning writes the display list into memory at the configured base.
// - Engine reads list and textures, writes image to frame buffer.
// - Only visible pixels are textured and shaded.
// - Depth setup solves A, B, C of the plane through three vertices.
// - Plane determinant is exported so tiny polygons can be culled.
// - Depth setup takes 14 clock cycles per polygon.
// - Shade setup computes shading and texture planes according to mode.
// - Shade results live in a cache; setup runs only on a miss.
// - One shade setup takes 48 to 70 cycles.
`timescale 1ns/1ns
`default_nettype none
module tps_setup_core
   import tps_pkg::*;
#(
   parameter logic [31:0] CULL_MIN = CULL_MIN_DEFAULT
) (
   input wire logic clk_sys_i,                      // System clock, 10 MHz
   input wire logic arst_n_i,                       // Async reset, active low
   input wire logic vtx_valid_i,                    // Vertex offered
   output logic vtx_ready_o,                        // Vertex taken when both high
   input wire tps_vertex_t vtx_i,                   // Screen-space vertex
   input wire tps_shape_t shape_i,                  // Shape of current primitive
   input wire logic strip_end_i,                    // Vertex closes the strip
   input wire logic [POLY_ID_W-1:0] poly_id_i,      // Polygon parameter handle
   output tps_plane_t plane_o,                      // Latest depth plane
   output logic plane_valid_o,                      // Plane pulse
   input wire logic [DL_ADDR_W-1:0] dl_base_i,      // Display list region base
   output logic dl_wr_o,                            // List entry write request
   output logic [DL_ADDR_W-1:0] dl_addr_o,          // List entry address
   output tps_dl_entry_t dl_data_o,                 // List entry
   input wire logic dl_ready_i,                     // Memory takes entry
   input wire logic render_start_i,                 // Start a frame pulse
   input wire logic [TILE_W-1:0] tiles_w_i,         // Tiles per row minus one
   input wire logic [TILE_W-1:0] tiles_h_i,         // Tile rows minus one
   output logic [TILE_W-1:0] tile_x_o,              // Tile being rendered
   output logic [TILE_W-1:0] tile_y_o,              // Tile row being rendered
   output logic tile_active_o,                      // Render in progress
   output logic render_done_o,                      // Frame finished pulse
   input wire logic frag_valid_i,                   // Fragment offered
   output logic frag_ready_o,                       // Fragment taken when both high
   input wire tps_frag_t frag_i,                    // Fragment after depth sort
   output logic pix_valid_o,                        // Frame buffer write pulse
   output tps_pixel_t pix_o                         // Shaded pixel
);
   // ***********************************************
   // Polygon intake and depth setup
   // ***********************************************
   typedef enum logic [1:0] {
      G_COLLECT = 2'b00,
      G_SETUP = 2'b01,
      G_BIN = 2'b10
   } tps_gstate_t;

   tps_gstate_t gstate;
   tps_vertex_t v [0:3];
   logic [1:0] vcnt;
   logic is_quad;
   logic strip_done;
   logic [POLY_ID_W-1:0] poly_id;
   logic [CNT_W-1:0] setup_cnt;
   logic [TILE_W-1:0] bx, by, bx_min, bx_max, by_min, by_max;
   logic [DL_ADDR_W-1:0] dl_ptr;

   wire logic vtx_take = vtx_valid_i && vtx_ready_o;
   wire logic last_corner = (vcnt == 2'h2) && (shape_i != SHAPE_QUAD);
   wire logic setup_trigger = vtx_take && (vcnt == 2'h3 || last_corner);
   wire logic setup_end = (gstate == G_SETUP) && (setup_cnt == '0);

   assign vtx_ready_o = (gstate == G_COLLECT);

   // Signed operands of the adjoint
   wire logic signed [12:0] sx0 = $signed({1'b0, v[0].x});
   wire logic signed [12:0] sx1 = $signed({1'b0, v[1].x});
   wire logic signed [12:0] sx2 = $signed({1'b0, v[2].x});
   wire logic signed [12:0] sy0 = $signed({1'b0, v[0].y});
   wire logic signed [12:0] sy1 = $signed({1'b0, v[1].y});
   wire logic signed [12:0] sy2 = $signed({1'b0, v[2].y});
   wire logic signed [16:0] sz0 = $signed({1'b0, v[0].z});
   wire logic signed [16:0] sz1 = $signed({1'b0, v[1].z});
   wire logic signed [16:0] sz2 = $signed({1'b0, v[2].z});
   wire logic signed [12:0] dy12 = sy1 - sy2;
   wire logic signed [12:0] dy20 = sy2 - sy0;
   wire logic signed [12:0] dy01 = sy0 - sy1;
   wire logic signed [12:0] dx21 = sx2 - sx1;
   wire logic signed [12:0] dx02 = sx0 - sx2;
   wire logic signed [12:0] dx10 = sx1 - sx0;
   wire logic signed [26:0] cr12 = 27'(sx1 * sy2) - 27'(sx2 * sy1);
   wire logic signed [26:0] cr20 = 27'(sx2 * sy0) - 27'(sx0 * sy2);
   wire logic signed [26:0] cr01 = 27'(sx0 * sy1) - 27'(sx1 * sy0);

   wire logic signed [31:0] a_num = 32'(sz0 * dy12) + 32'(sz1 * dy20) + 32'(sz2 * dy01);
   wire logic signed [31:0] b_num = 32'(sz0 * dx21) + 32'(sz1 * dx02) + 32'(sz2 * dx10);
   wire logic signed [47:0] c_num = 48'(sz0 * cr12) + 48'(sz1 * cr20) + 48'(sz2 * cr01);
   wire logic signed [31:0] det = 32'(sx0 * dy12) + 32'(sx1 * dy20) + 32'(sx2 * dy01);
   wire logic [31:0] det_mag = det[31] ? 32'(-det) : det;
   wire logic culled = det_mag < CULL_MIN;
   // Fourth quad vertex: z times det from the plane
   wire logic signed [63:0] quad_z_num = 64'(a_num * $signed({1'b0, v[3].x}))
      + 64'(b_num * $signed({1'b0, v[3].y})) + 64'(c_num);

   // Bounding box in tile units, quad includes its fourth corner
   function automatic logic [COORD_W-1:0] cmin(input logic [COORD_W-1:0] a, b);
      cmin = (a < b) ? a : b;
   endfunction
   function automatic logic [COORD_W-1:0] cmax(input logic [COORD_W-1:0] a, b);
      cmax = (a > b) ? a : b;
   endfunction
   wire logic [COORD_W-1:0] x3 = is_quad ? v[3].x : v[2].x;
   wire logic [COORD_W-1:0] y3 = is_quad ? v[3].y : v[2].y;
   wire logic [COORD_W-1:0] x_lo = cmin(cmin(v[0].x, v[1].x), cmin(v[2].x, x3));
   wire logic [COORD_W-1:0] x_hi = cmax(cmax(v[0].x, v[1].x), cmax(v[2].x, x3));
   wire logic [COORD_W-1:0] y_lo = cmin(cmin(v[0].y, v[1].y), cmin(v[2].y, y3));
   wire logic [COORD_W-1:0] y_hi = cmax(cmax(v[0].y, v[1].y), cmax(v[2].y, y3));
   wire logic [TILE_W-1:0] nx_min = x_lo[COORD_W-1:TILE_SHIFT];
   wire logic [TILE_W-1:0] nx_max = x_hi[COORD_W-1:TILE_SHIFT];
   wire logic [TILE_W-1:0] ny_min = y_lo[COORD_W-1:TILE_SHIFT];
   wire logic [TILE_W-1:0] ny_max = y_hi[COORD_W-1:TILE_SHIFT];

   wire logic bin_step = (gstate == G_BIN) && dl_ready_i;
   wire logic bin_last = (bx == bx_max) && (by == by_max);

   assign dl_wr_o = (gstate == G_BIN);
   assign dl_addr_o = dl_base_i + dl_ptr;
   assign dl_data_o = '{tile_x: bx, tile_y: by, poly_id: poly_id};

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         gstate <= G_COLLECT;
         vcnt <= 2'h0;
         is_quad <= 1'b0;
         strip_done <= 1'b0;
         poly_id <= '0;
         setup_cnt <= '0;
      end else begin
         case (gstate)
            G_COLLECT: begin
               if (vtx_take) begin
                  poly_id <= poly_id_i;
                  is_quad <= (shape_i == SHAPE_QUAD);
                  strip_done <= (shape_i != SHAPE_STRIP) || strip_end_i;
                  if (vcnt != 2'h3) begin
                     vcnt <= vcnt + 2'h1;
                  end
               end
               if (setup_trigger) begin
                  gstate <= G_SETUP;
                  // Start edge and output register take two of the cycles
                  setup_cnt <= DEPTH_SETUP_CYC - 7'h02;
               end
            end
            G_SETUP: begin
               setup_cnt <= setup_cnt - 7'h01;
               if (setup_end) begin
                  gstate <= culled ? G_COLLECT : G_BIN;
                  if (culled && strip_done) begin
                     vcnt <= 2'h0;
                  end
               end
            end
            G_BIN: begin
               if (bin_step && bin_last) begin
                  gstate <= G_COLLECT;
                  if (strip_done) begin
                     vcnt <= 2'h0;
                  end
               end
            end
            default: gstate <= G_COLLECT;
         endcase
      end
   end

   // Vertex window; a strip slides by one per new vertex
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int i = 0; i < 4; i++) begin
            v[i] <= '0;
         end
      end else if (vtx_take) begin
         if (vcnt != 2'h3) begin
            v[vcnt] <= vtx_i;
         end else if (shape_i == SHAPE_QUAD) begin
            v[3] <= vtx_i;
         end else begin
            v[0] <= v[1];
            v[1] <= v[2];
            v[2] <= vtx_i;
         end
      end
   end

   // Plane result and tile walk over the bounding box
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         plane_o <= '0;
         plane_valid_o <= 1'b0;
         bx <= '0;
         by <= '0;
         bx_min <= '0;
         bx_max <= '0;
         by_min <= '0;
         by_max <= '0;
         dl_ptr <= '0;
      end else begin
         plane_valid_o <= setup_end;
         if (setup_end) begin
            plane_o <= '{a_num: a_num, b_num: b_num, c_num: c_num, det: det,
                         quad_z_num: is_quad ? quad_z_num : 64'sh0, culled: culled};
            bx <= nx_min;
            by <= ny_min;
            bx_min <= nx_min;
            bx_max <= nx_max;
            by_min <= ny_min;
            by_max <= ny_max;
         end
         if (render_start_i) begin
            dl_ptr <= '0;
         end else if (bin_step) begin
            dl_ptr <= dl_ptr + 24'h000001;
         end
         if (bin_step) begin
            if (bx == bx_max) begin
               bx <= bx_min;
               by <= by + 7'h01;
            end else begin
               bx <= bx + 7'h01;
            end
         end
      end
   end

   // ***********************************************
   // Tile walk and shading with parameter cache
   // ***********************************************
   typedef enum logic [1:0] {
      R_IDLE = 2'b00,
      R_TILE = 2'b01,
      R_SHADE = 2'b10
   } tps_rstate_t;

   tps_rstate_t rstate;
   tps_frag_t frag;
   logic [TILE_W-1:0] frag_tx, frag_ty;
   logic [CNT_W-1:0] shade_cnt;
   logic [COL_W-1:0] cache_col [0:CACHE_DEPTH-1];
   logic [POLY_ID_W-1:0] cache_tag [0:CACHE_DEPTH-1];
   logic [CACHE_DEPTH-1:0] cache_vld;

   wire logic frag_take = frag_valid_i && frag_ready_o;
   wire logic [CACHE_AW-1:0] look_idx = frag_i.poly_id[CACHE_AW-1:0];
   wire logic [CACHE_AW-1:0] fill_idx = frag.poly_id[CACHE_AW-1:0];
   wire logic cache_hit = cache_vld[look_idx] && (cache_tag[look_idx] == frag_i.poly_id);
   wire logic shade_req = frag_take && frag_i.visible;
   wire logic shade_miss = shade_req && !cache_hit;
   wire logic shade_fill = (rstate == R_SHADE) && (shade_cnt == '0);
   wire logic textured = (frag_i.ptype != PT_FLAT) && (frag_i.ptype != PT_GOURAUD);
   wire logic has_offset = (frag.ptype == PT_TEX_FLAT_OFS) || (frag.ptype == PT_TEX_GOURAUD_OFS);
   wire logic tile_last = (rstate == R_TILE && frag_take && frag_i.last && !shade_miss)
      || (shade_fill && frag.last);
   wire logic frame_last = (tile_x_o == tiles_w_i) && (tile_y_o == tiles_h_i);
   logic [COL_W-1:0] sum_col;
   wire logic [COL_W-1:0] shade_col = (frag.combine_add && has_offset) ? sum_col : frag.base_col;

   for (genvar c = 0; c < 3; c++) begin : g_ch
      logic [CH_W:0] ch_sum;
      assign ch_sum = {1'b0, frag.base_col[CH_W*c +: CH_W]} + {1'b0, frag.offset_col[CH_W*c +: CH_W]};
      assign sum_col[CH_W*c +: CH_W] = ch_sum[CH_W] ? 8'hff : ch_sum[CH_W-1:0];
   end

   assign frag_ready_o = (rstate == R_TILE);
   assign tile_active_o = (rstate != R_IDLE);

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rstate <= R_IDLE;
         frag <= '0;
         frag_tx <= '0;
         frag_ty <= '0;
         shade_cnt <= '0;
         tile_x_o <= '0;
         tile_y_o <= '0;
         render_done_o <= 1'b0;
      end else begin
         render_done_o <= 1'b0;
         case (rstate)
            R_IDLE: begin
               if (render_start_i) begin
                  rstate <= R_TILE;
                  tile_x_o <= '0;
                  tile_y_o <= '0;
               end
            end
            R_TILE: begin
               if (frag_take) begin
                  frag <= frag_i;
                  // Pixel keeps its tile even when the tile ends on it
                  frag_tx <= tile_x_o;
                  frag_ty <= tile_y_o;
               end
               if (shade_miss) begin
                  rstate <= R_SHADE;
                  shade_cnt <= (textured ? SHADE_SETUP_MAX : SHADE_SETUP_MIN) - 7'h02;
               end
            end
            R_SHADE: begin
               shade_cnt <= shade_cnt - 7'h01;
               if (shade_fill) begin
                  rstate <= R_TILE;
               end
            end
            default: rstate <= R_IDLE;
         endcase
         if (tile_last) begin
            if (frame_last) begin
               rstate <= R_IDLE;
               render_done_o <= 1'b1;
            end else if (tile_x_o == tiles_w_i) begin
               tile_x_o <= '0;
               tile_y_o <= tile_y_o + 7'h01;
            end else begin
               tile_x_o <= tile_x_o + 7'h01;
            end
         end
      end
   end

   // Cache fill and frame buffer output, one cycle after the colour is known
   logic hit_pend;
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cache_vld <= '0;
         hit_pend <= 1'b0;
         pix_valid_o <= 1'b0;
         pix_o <= '0;
         for (int i = 0; i < CACHE_DEPTH; i++) begin
            cache_col[i] <= '0;
            cache_tag[i] <= '0;
         end
      end else begin
         hit_pend <= shade_req && cache_hit;
         if (render_start_i) begin
            cache_vld <= '0;
         end else if (shade_fill) begin
            cache_vld[fill_idx] <= 1'b1;
            cache_col[fill_idx] <= shade_col;
            cache_tag[fill_idx] <= frag.poly_id;
         end
         pix_valid_o <= hit_pend || shade_fill;
         if (hit_pend || shade_fill) begin
            pix_o.x <= {frag_tx, frag.px};
            pix_o.y <= {frag_ty, frag.py};
            pix_o.colour <= shade_fill ? shade_col : cache_col[fill_idx];
         end
      end
   end

   // ***********************************************
   // Checks
   // ***********************************************
   a_setup_fourteen: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      setup_trigger |-> ##14 plane_valid_o) else $error("depth setup not 14 cycles");
   a_ready_collect: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      (plane_valid_o && !plane_o.culled) |-> !vtx_ready_o [*1])
      else $error("vertex taken during setup");
   a_cull_no_bin: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      (plane_valid_o && plane_o.culled) |-> !dl_wr_o) else $error("culled polygon binned");
   a_bin_addr_step: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      (dl_wr_o && dl_ready_i && !render_start_i) |=> dl_ptr == $past(dl_ptr) + 24'h000001)
      else $error("list address did not advance");
   a_bin_in_box: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      dl_wr_o |-> (bx >= bx_min && bx <= bx_max && by >= by_min && by <= by_max))
      else $error("tile outside polygon box");
   a_miss_latency: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      (shade_miss && !textured) |-> ##48 pix_valid_o) else $error("shade setup not 48");
   a_miss_tex_lat: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      (shade_miss && textured) |-> ##70 pix_valid_o) else $error("texture setup not 70");
   a_hit_fast: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      (shade_req && cache_hit) |-> ##2 pix_valid_o) else $error("cache hit recomputed");
   a_hidden_skip: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      (frag_take && !frag_i.visible && rstate == R_TILE) |=> !shade_fill ##1 !pix_valid_o)
      else $error("hidden pixel shaded");
   a_tile_raster: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      (tile_last && !frame_last && tile_x_o != tiles_w_i) |=> tile_x_o == $past(tile_x_o) + 7'h01
      && $stable(tile_y_o)) else $error("tile order broken");
   c_strip_chain: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      setup_trigger && vcnt == 2'h3 && shape_i == SHAPE_STRIP);
   c_quad_setup: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      plane_valid_o && is_quad);
   c_cache_hit: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      shade_req && cache_hit);
   c_frame_done: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i) render_done_o);
endmodule
`default_nettype wire

// [testbench/tps_host_model.sv]
// Purpose: Host model offering screen-space vertices to the intake
// Assumes: Caller already scaled x and y by the inverse w coordinate
// Notes: A released vertex bus shows the inverted last vertex
`timescale 1ns/1ns
`default_nettype none
module tps_host_model
   import tps_pkg::*;
(
   input wire logic clk_sys_i,            // System clock
   input wire logic vtx_ready_i,          // Intake ready
   output logic vtx_valid_o,              // Vertex offered
   output tps_vertex_t vtx_o,             // Vertex
   output tps_shape_t shape_o,            // Shape of primitive
   output logic strip_end_o,              // Strip close flag
   output logic [POLY_ID_W-1:0] poly_id_o // Polygon handle
);
   initial begin
      vtx_valid_o = 1'b0;
      vtx_o = '0;
      shape_o = SHAPE_TRI;
      strip_end_o = 1'b0;
      poly_id_o = '0;
   end
   // Offer one vertex and hold it until taken
   task automatic send(input tps_vertex_t v, input tps_shape_t s, input logic [15:0] id);
      @(negedge clk_sys_i);
      vtx_o = v;
      shape_o = s;
      poly_id_o = id;
      vtx_valid_o = 1'b1;
      while (vtx_ready_i !== 1'b1) @(negedge clk_sys_i);
      @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      vtx_valid_o = 1'b0;
      vtx_o = ~v;
   endtask
endmodule
`default_nettype wire

// [testbench/tile_polygon_setup_bench.sv]
// Purpose: Self-checking bench of the polygon setup core
// Assumes: List memory stalls at random
// Notes: Cache and colour model kept in integer arrays
`timescale 1ns/1ns
`default_nettype none
module tile_polygon_setup_bench
   import tps_pkg::*;
;
   logic clk = 1'b0, arst_n = 1'b0, vv, vr, se, dl_wr, dl_ready = 1'b0, rs = 1'b0, act, done;
   logic pv, fv = 1'b0, fr, pixv, seen_done = 1'b0;
   tps_vertex_t vtx;
   tps_shape_t shp;
   logic [15:0] pid;
   tps_plane_t pl;
   logic [23:0] dl_addr, dl_base = 24'h00a000;
   tps_dl_entry_t dl_data;
   logic [6:0] tw = 7'h02, th = 7'h00, tx, ty;
   tps_frag_t frag = '0;
   tps_pixel_t pix;
   logic [53:0] dl_q[$];
   int vx[4] = '{10, 70, 20, 40}, vy[4] = '{5, 8, 40, 20}, vz[4] = '{100, 200, 300, 50};
   int fail_count = 0, n_tests = 0, ptr = 0, tile = 0, tag[8], col[8];
   always #50 clk = ~clk;
   tps_host_model host (.clk_sys_i(clk), .vtx_ready_i(vr), .vtx_valid_o(vv), .vtx_o(vtx),
      .shape_o(shp), .strip_end_o(se), .poly_id_o(pid));
   tps_setup_core uut (.clk_sys_i(clk), .arst_n_i(arst_n), .vtx_valid_i(vv), .vtx_ready_o(vr),
      .vtx_i(vtx), .shape_i(shp), .strip_end_i(se), .poly_id_i(pid), .plane_o(pl),
      .plane_valid_o(pv), .dl_base_i(dl_base), .dl_wr_o(dl_wr), .dl_addr_o(dl_addr),
      .dl_data_o(dl_data), .dl_ready_i(dl_ready), .render_start_i(rs), .tiles_w_i(tw),
      .tiles_h_i(th), .tile_x_o(tx), .tile_y_o(ty), .tile_active_o(act), .render_done_o(done),
      .frag_valid_i(fv), .frag_ready_o(fr), .frag_i(frag), .pix_valid_o(pixv), .pix_o(pix));
   // ***********************************************
   // Memory stall and list capture
   // ***********************************************
   always @(negedge clk) begin
      dl_ready = 1'($urandom);
      if (dl_wr === 1'b1 && dl_ready) dl_q.push_back({dl_addr, dl_data});
      if (done === 1'b1) seen_done = 1'b1;
   end
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // ***********************************************
   // Polygon intake, plane and binning
   // ***********************************************
   task automatic poly(input tps_shape_t s, input int nv, input int ne);
      longint d, a, b, c;
      int n, k;
      dl_q.delete();
      for (int i = 0; i < nv; i++) host.send({12'(vx[i]), 12'(vy[i]), 16'(vz[i])}, s, 16'h0005);
      n = 1;
      while (pv !== 1'b1 && n < 40) begin @(negedge clk); n++; end
      d = vx[0] * (vy[1] - vy[2]) + vx[1] * (vy[2] - vy[0]) + vx[2] * (vy[0] - vy[1]);
      a = vz[0] * (vy[1] - vy[2]) + vz[1] * (vy[2] - vy[0]) + vz[2] * (vy[0] - vy[1]);
      b = vz[0] * (vx[2] - vx[1]) + vz[1] * (vx[0] - vx[2]) + vz[2] * (vx[1] - vx[0]);
      c = vz[0] * (vx[1] * vy[2] - vx[2] * vy[1]) + vz[1] * (vx[2] * vy[0] - vx[0] * vy[2])
         + vz[2] * (vx[0] * vy[1] - vx[1] * vy[0]);
      check(n, 14);
      check({pl.culled, pl.det}, {d == 0, 32'(d)});
      check({pl.a_num, pl.b_num}, {32'(a), 32'(b)});
      check(pl.c_num, c);
      if (nv == 4) check(pl.quad_z_num, a * vx[3] + b * vy[3] + c);
      n = 0;
      while (vr !== 1'b1 && n < 300) begin @(negedge clk); n++; end
      check(dl_q.size(), ne);
      k = 0;
      for (int y = 0; y < ne / 3; y++) for (int x = 0; x < 3; x++) begin
         check(dl_q[k], {24'(dl_base + ptr), 7'(x), 7'(y), 16'h0005});
         k++;
         ptr++;
      end
   endtask
   // ***********************************************
   // Fragment shading with cache model
   // ***********************************************
   task automatic frg(input int id, input tps_ptype_t pt, input logic vis, input logic lst);
      tps_frag_t f;
      int lat, ec, n, i;
      f = {16'(id), pt, 1'b1, vis, lst, 5'($urandom), 5'($urandom), 24'($urandom), 24'($urandom)};
      i = id % 8;
      lat = (tag[i] == id) ? 2 : ((pt >= PT_TEX_FLAT) ? 70 : 48);
      ec = (tag[i] == id) ? col[i] : f.base_col;
      if (tag[i] != id && pt >= PT_TEX_FLAT_OFS) for (int k = 0; k < 24; k += 8) begin
         n = f.base_col[k+:8] + f.offset_col[k+:8];
         ec[k+:8] = (n > 255) ? 8'hff : n[7:0];
      end
      @(negedge clk);
      frag = f;
      fv = 1'b1;
      while (fr !== 1'b1) @(negedge clk);
      @(posedge clk);
      @(negedge clk);
      fv = 1'b0;
      frag = ~f;
      n = 1;
      while (pixv !== 1'b1 && n < 80) begin @(negedge clk); n++; end
      check(n, vis ? lat : 80);
      if (vis) begin
         check(pix, {12'(tile * 32 + f.px), 12'(f.py), 24'(ec)});
         tag[i] = id;
         col[i] = ec;
      end
      if (lst) tile++;
   endtask
   initial begin
      #3000000;
      fail_count++;
      close_out();
   end
   initial begin
      void'($urandom(81));
      for (int i = 0; i < 8; i++) tag[i] = -1;
      repeat (3) @(negedge clk);
      arst_n = 1'b1;
      check({vr, pv, act}, 3'b100);
      poly(SHAPE_TRI, 3, 6);
      poly(SHAPE_QUAD, 4, 6);
      vy = '{5, 5, 5, 20};
      poly(SHAPE_TRI, 3, 0);
      @(negedge clk);
      rs = 1'b1;
      @(negedge clk);
      rs = 1'b0;
      check({act, tx, ty}, {1'b1, 14'h0});
      frg(3, PT_FLAT, 1'b0, 1'b0);
      frg(3, PT_FLAT, 1'b1, 1'b0);
      frg(3, PT_FLAT, 1'b1, 1'b1);
      frg(11, PT_TEX_GOURAUD_OFS, 1'b1, 1'b0);
      frg(3, PT_TEX_FLAT, 1'b1, 1'b1);
      check(tx, 7'h02);
      for (int k = 0; k < 6; k++) frg(16 + k, tps_ptype_t'(k), 1'b1, 1'b0);
      frg(16, PT_GOURAUD, 1'b1, 1'b0);
      frg(9, PT_FLAT, 1'b0, 1'b1);
      check({seen_done, act}, 2'b10);
      close_out();
   end
endmodule
`default_nettype wire
